// ==== rtl/dhc_debug_halt_control.v ====
// Debug run control and state report registers with CPU halt, break and step control.
// Assumes the CPU core, clock control and serial debug link run on CLOCK; status
// inputs from them are synchronous and need no synchroniser.
//
// Notes on behaviour
// - Writing halt request one halts the CPU.
// - Halted CPU fetches nothing until released or stepped.
// - Clearing halt request resumes normal running.
// - Breakpoint with halt-on-break sets halt request.
// - Breakpoint without halt-on-break loops current instruction.
// - Breakpoint enable picks trap or breakpoint.
// - Stop-debug bit keeps clock running in stop.
// - Step bit while halted runs one instruction.
// - Step bit clears after the instruction completes.
// - Status bit 7 shows debug-halt state.
// - Break instruction sets break-reached status.
// - Writing halt request zero clears break-reached.
// - Status bit 5 shows halt mode.
// - Status bit 4 shows stop mode.
// - Status bit 3 shows read protection on.
// - Reserved status bit 2 reads zero.
// - Status bit 1 shows transmit holding full.
// - Status bit 0 shows receive holding empty.
// - CPU writes blocked while debug lock set.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "dhc_defines.vh"

module dhc_debug_halt_control
(
  CLOCK,
  RST_N,
  AVS_ADDRESS,
  AVS_READ,
  AVS_WRITE,
  AVS_WRITEDATA,
  AVS_BYTEENABLE,
  AVS_READDATA,
  AVS_WAITREQUEST,
  HOST_ACCESS,
  BRK_INSN,
  HW_BREAK,
  INSN_DONE,
  CPU_IN_HALT,
  CPU_IN_STOP,
  READ_PROTECT_ON,
  TX_HOLDING_FULL,
  RX_HOLDING_EMPTY,
  FETCH_ENABLE,
  LOOP_ON_BREAK,
  ILLEGAL_TRAP,
  STOP_CLOCK_RUN
);

  input  wire        CLOCK;
  input  wire        RST_N;
  input  wire [3:0]  AVS_ADDRESS;
  input  wire        AVS_READ;
  input  wire        AVS_WRITE;
  input  wire [31:0] AVS_WRITEDATA;
  input  wire [3:0]  AVS_BYTEENABLE;
  output reg  [31:0] AVS_READDATA;
  output reg         AVS_WAITREQUEST;
  input  wire        HOST_ACCESS;
  input  wire        BRK_INSN;
  input  wire        HW_BREAK;
  input  wire        INSN_DONE;
  input  wire        CPU_IN_HALT;
  input  wire        CPU_IN_STOP;
  input  wire        READ_PROTECT_ON;
  input  wire        TX_HOLDING_FULL;
  input  wire        RX_HOLDING_EMPTY;
  output reg         FETCH_ENABLE;
  output reg         LOOP_ON_BREAK;
  output reg         ILLEGAL_TRAP;
  output reg         STOP_CLOCK_RUN;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: each access waits one cycle, then is answered.

  reg         ack_q;
  reg         ack_d;
  reg         wait_d;
  reg  [7:0]  ctrl_q;
  reg  [7:0]  ctrl_d;
  reg         lock_q;
  reg         lock_d;
  reg         brk_seen_q;
  reg         brk_seen_d;
  reg         step_run_q;
  reg         step_run_d;
  reg         loop_q;
  reg         loop_d;
  reg         fetch_d;
  reg         loop_out_d;
  reg         trap_d;
  reg         stop_run_d;
  reg  [31:0] rd_d;
  reg  [31:0] rd_hold_d;
  wire        req;
  wire        wr_go;
  wire        sel_ctrl;
  wire        sel_lock;
  wire        wr_ctrl;
  wire        wr_lock;
  wire        wr_pass;
  wire        halt_req;
  wire        halt_brk;
  wire        brk_en;
  wire        stop_dbg;
  wire        step_bit;
  wire        bp_event;
  wire        bp_source;
  wire        brk_break;
  wire        hw_break;
  wire        step_start;
  wire        step_end;
  wire [7:0]  status;

  assign req      = AVS_READ | AVS_WRITE;
  assign wr_go    = AVS_WRITE & ack_q;
  assign sel_ctrl = (AVS_ADDRESS == `DHC_OFS_RUN_CTRL);
  assign sel_lock = (AVS_ADDRESS == `DHC_OFS_LOCK);
  // Lock blocks CPU writes; the debug host (HOST_ACCESS) may still write.
  assign wr_pass  = ~lock_q | HOST_ACCESS;
  assign wr_ctrl  = wr_go & sel_ctrl & AVS_BYTEENABLE[0] & wr_pass;
  assign wr_lock  = wr_go & sel_lock & AVS_BYTEENABLE[0] & wr_pass;

  // Field views of the run control register.
  assign halt_req = ctrl_q[`DHC_BIT_HALT_REQ];
  assign halt_brk = ctrl_q[`DHC_BIT_HALT_BRK];
  assign brk_en   = ctrl_q[`DHC_BIT_BRK_EN];
  assign stop_dbg = ctrl_q[`DHC_BIT_STOP_DBG];
  assign step_bit = ctrl_q[`DHC_BIT_STEP];

  always @*
  begin
    ack_d  = req & ~ack_q;
    wait_d = ~(req & ~ack_q);
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ack_q           <= 1'h0;
      AVS_WAITREQUEST <= 1'h1;
    end
    else
    begin
      ack_q           <= ack_d;
      AVS_WAITREQUEST <= wait_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Breakpoint routing: with breakpoints disabled both sources trap instead.

  assign bp_source = BRK_INSN | HW_BREAK;
  assign brk_break = BRK_INSN & brk_en;
  assign hw_break  = HW_BREAK & brk_en;
  assign bp_event  = brk_break | hw_break;

  always @*
  begin
    trap_d = bp_source & ~brk_en;
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
      ILLEGAL_TRAP <= 1'h0;
    else
      ILLEGAL_TRAP <= trap_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Run control register. Reserved bits 3:1 are not stored and read zero.

  assign step_start = halt_req & step_bit & ~step_run_q & ~INSN_DONE;
  assign step_end   = step_run_q & INSN_DONE;

  always @*
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = AVS_WRITEDATA[7:0] & `DHC_RUN_CTRL_WMASK;
    if (bp_event & halt_brk)
      ctrl_d[`DHC_BIT_HALT_REQ] = 1'h1;
    // A step ends after one instruction and leaves halt request set.
    if (step_end & ~(wr_ctrl & AVS_WRITEDATA[`DHC_BIT_STEP]))
      ctrl_d[`DHC_BIT_STEP] = 1'h0;
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
      ctrl_q <= `DHC_RUN_CTRL_RST;
    else
      ctrl_q <= ctrl_d;
  end

  always @*
  begin
    lock_d = lock_q;
    if (wr_lock)
      lock_d = AVS_WRITEDATA[0];
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
      lock_q <= `DHC_LOCK_RST;
    else
      lock_q <= lock_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fetch gating: halted CPU fetches only while a single step is in flight.

  always @*
  begin
    step_run_d = step_run_q;
    if (step_end)
      step_run_d = 1'h0;
    else if (step_start)
      step_run_d = 1'h1;
  end

  always @*
  begin
    fetch_d = ~halt_req | (step_run_q & ~INSN_DONE);
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      step_run_q   <= 1'h0;
      FETCH_ENABLE <= 1'h1;
    end
    else
    begin
      step_run_q   <= step_run_d;
      FETCH_ENABLE <= fetch_d;
    end
  end

  // Loop on the breakpoint until halt-on-break is set or breakpoint enable is cleared.
  always @*
  begin
    loop_d = loop_q;
    if (halt_brk | ~brk_en)
      loop_d = 1'h0;
    else if (bp_event)
      loop_d = 1'h1;
    loop_out_d = loop_q | (bp_event & ~halt_brk);
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      loop_q        <= 1'h0;
      LOOP_ON_BREAK <= 1'h0;
    end
    else
    begin
      loop_q        <= loop_d;
      LOOP_ON_BREAK <= loop_out_d;
    end
  end

  always @*
  begin
    stop_run_d = stop_dbg;
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
      STOP_CLOCK_RUN <= 1'h0;
    else
      STOP_CLOCK_RUN <= stop_run_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Break-reached flag: a new break wins over the clear.

  always @*
  begin
    brk_seen_d = brk_seen_q;
    if (BRK_INSN)
      brk_seen_d = 1'h1;
    else if (wr_ctrl & ~AVS_WRITEDATA[`DHC_BIT_HALT_REQ])
      brk_seen_d = 1'h0;
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
      brk_seen_q <= 1'h0;
    else
      brk_seen_q <= brk_seen_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State report and read data.

  assign status[`DHC_BIT_ST_DHALT]   = halt_req & ~step_run_q;
  assign status[`DHC_BIT_ST_BRK]     = brk_seen_q;
  assign status[`DHC_BIT_ST_HALT]    = CPU_IN_HALT;
  assign status[`DHC_BIT_ST_STOP]    = CPU_IN_STOP;
  assign status[`DHC_BIT_ST_RPROT]   = READ_PROTECT_ON;
  assign status[`DHC_BIT_ST_RSVD]    = 1'h0;
  assign status[`DHC_BIT_ST_TXFULL]  = TX_HOLDING_FULL;
  assign status[`DHC_BIT_ST_RXEMPTY] = RX_HOLDING_EMPTY;

  always @*
  begin
    rd_d = `DHC_UNMAPPED_RD;
    case (AVS_ADDRESS)
      `DHC_OFS_RUN_CTRL:  rd_d = {24'h00_0000, ctrl_q};
      `DHC_OFS_STATE_RPT: rd_d = {24'h00_0000, status};
      `DHC_OFS_LOCK:      rd_d = {31'h0000_0000, lock_q};
      default:            rd_d = `DHC_UNMAPPED_RD;
    endcase
  end

  // Read data is captured in the waiting cycle and stands through the answer.
  always @*
  begin
    rd_hold_d = AVS_READDATA;
    if (AVS_READ & ~ack_q)
      rd_hold_d = rd_d;
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
      AVS_READDATA <= `DHC_UNMAPPED_RD;
    else
      AVS_READDATA <= rd_hold_d;
  end

endmodule

// ==== rtl/dhc_defines.vh ====
// Constants of the debug halt control block: register offsets, bit fields and resets.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
`ifndef DHC_DEFINES_VH
`define DHC_DEFINES_VH

`define DHC_ADDR_W          4
`define DHC_OFS_RUN_CTRL    4'h0
`define DHC_OFS_STATE_RPT   4'h4
`define DHC_OFS_LOCK        4'h8

`define DHC_BIT_HALT_REQ    7
`define DHC_BIT_HALT_BRK    6
`define DHC_BIT_BRK_EN      5
`define DHC_BIT_STOP_DBG    4
`define DHC_BIT_STEP        0

`define DHC_BIT_ST_DHALT    7
`define DHC_BIT_ST_BRK      6
`define DHC_BIT_ST_HALT     5
`define DHC_BIT_ST_STOP     4
`define DHC_BIT_ST_RPROT    3
`define DHC_BIT_ST_RSVD     2
`define DHC_BIT_ST_TXFULL   1
`define DHC_BIT_ST_RXEMPTY  0

`define DHC_RUN_CTRL_RST    8'h00
`define DHC_RUN_CTRL_WMASK  8'hF1
`define DHC_LOCK_RST        1'h0
`define DHC_UNMAPPED_RD     32'h0000_0000

`endif

// ==== dv/dhc_cpu_model.sv ====
// CPU core stand-in: completes one instruction every LAT cycles while fetch is on.
// Assumes the clock, reset and fetch enable of the debug halt control.
`timescale 1ns/100ps

module dhc_cpu_model #(parameter int LAT = 3)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fetch,
  output logic      done
);
  int c;
  always @(posedge clk)
  begin
    done <= fetch && rst_n && c == LAT - 1;
    c    <= (!fetch || !rst_n || c == LAT - 1) ? 0 : c + 1;
  end
endmodule

// ==== dv/dhc_debug_halt_control_assertions.sv ====
// Checker of bus timing and CPU-side outputs of the debug halt control.
// Assumes it sees only the top module's ports, bound below.
`timescale 1ns/100ps

module dhc_debug_halt_control_assertions
(
  input wire logic        CLOCK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, HOST_ACCESS,
  input wire logic        BRK_INSN, HW_BREAK, INSN_DONE, FETCH_ENABLE, LOOP_ON_BREAK,
  input wire logic        ILLEGAL_TRAP,
  input wire logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire ctl = !AVS_WAITREQUEST && AVS_WRITE && AVS_ADDRESS == 4'h0
             && AVS_BYTEENABLE[0] && HOST_ACCESS;
  wire break_instruction = BRK_INSN || HW_BREAK;
  sequence halt_wr;
    ctl && AVS_WRITEDATA[7] && !AVS_WRITEDATA[0];
  endsequence
  sequence run_wr;
    ctl && !AVS_WRITEDATA[7] && !break_instruction;
  endsequence
  bus_wait_a: assert property
    ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("No ack.");
  ack_pulse_a: assert property
    (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("Ack too long.");
  idle_wait_a: assert property
    (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST) else $error("Ack without request.");
  halt_fetch_a: assert property
    (halt_wr |=> ##1 !FETCH_ENABLE) else $error("Fetch not stopped.");
  run_fetch_a: assert property
    (run_wr |-> ##2 FETCH_ENABLE) else $error("Fetch not resumed.");
  trap_cause_a: assert property
    (ILLEGAL_TRAP |-> $past(break_instruction)) else $error("Trap without break.");
  loop_cause_a: assert property
    ($rose(LOOP_ON_BREAK) |-> $past(break_instruction)) else $error("Loop without break.");
  stop_cause_a: assert property
    ($fell(FETCH_ENABLE) |-> !$past(AVS_WAITREQUEST, 2) || $past(break_instruction, 2) || $past(INSN_DONE))
    else $error("Fetch stopped without cause.");
endmodule

bind dhc_debug_halt_control dhc_debug_halt_control_assertions u_chk
  (.CLOCK, .RST_N, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .HOST_ACCESS, .BRK_INSN,
   .HW_BREAK, .INSN_DONE, .FETCH_ENABLE, .LOOP_ON_BREAK, .ILLEGAL_TRAP, .AVS_ADDRESS,
   .AVS_BYTEENABLE, .AVS_WRITEDATA);

// ==== dv/testbench.sv ====
// Self-checking bench of the debug halt control through its register bus.
// Assumes the CPU stand-in model supplies instruction completion.
`timescale 1ns/100ps

module testbench;
  logic        clk, rst_n, rd, wr, host, bi, hb, tseen;
  logic [3:0]  ad, be;
  logic [4:0]  st;
  logic [31:0] wd, rdat;
  wire  [31:0] q;
  wire         wrq, fe, lp, tr, sc, dn;
  int          errors = 0, num_checks = 0, cyc = 0, ndone = 0, n0 = 0;
  dhc_debug_halt_control dut (.CLOCK(clk), .RST_N(rst_n), .AVS_ADDRESS(ad), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(q),
    .AVS_WAITREQUEST(wrq), .HOST_ACCESS(host), .BRK_INSN(bi), .HW_BREAK(hb), .INSN_DONE(dn),
    .CPU_IN_HALT(st[4]), .CPU_IN_STOP(st[3]), .READ_PROTECT_ON(st[2]),
    .TX_HOLDING_FULL(st[1]), .RX_HOLDING_EMPTY(st[0]), .FETCH_ENABLE(fe),
    .LOOP_ON_BREAK(lp), .ILLEGAL_TRAP(tr), .STOP_CLOCK_RUN(sc));
  dhc_cpu_model cpu (.clk(clk), .rst_n(rst_n), .fetch(fe), .done(dn));
  task test_done;
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
      begin
        errors++;
        $display("Error %0t: got %h expected %h", $time, s, e);
      end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= {24'h00_0000, d};
    do @(posedge clk); while (wrq !== 1'h0);
    rdat = q;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(rdat, {24'h00_0000, e});
  endtask
  task wfe(input logic v);
    while (fe !== v) @(posedge clk);
  endtask
  task pulse(input logic h);
    @(posedge clk);
    bi <= !h;
    hb <= h;
    @(posedge clk);
    bi <= 1'h0;
    hb <= 1'h0;
    @(posedge clk);
    tseen = tr;
    repeat (2) @(posedge clk);
  endtask
  task t_halt_step;
    rdc(4'h0, 8'h00);
    rdc(4'h4, 8'h01);
    bus(1'h1, 4'h0, 8'h80);
    wfe(1'h0);
    rdc(4'h4, 8'h81);
    chk(fe, 1'h0);
    n0 = ndone;
    bus(1'h1, 4'h0, 8'h81);
    wfe(1'h1);
    wfe(1'h0);
    rdc(4'h0, 8'h80);
    chk(ndone - n0, 32'h0000_0001);
    bus(1'h1, 4'h0, 8'h00);
    rdc(4'h4, 8'h01);
    chk(fe, 1'h1);
    $display("Halt and step test done");
  endtask
  task t_break;
    bus(1'h1, 4'h0, 8'h20);
    pulse(1'h0);
    chk(tseen, 1'h0);
    chk(lp, 1'h1);
    rdc(4'h4, 8'h41);
    bus(1'h1, 4'h0, 8'h60);
    rdc(4'h4, 8'h01);
    pulse(1'h1);
    chk(lp, 1'h0);
    rdc(4'h0, 8'hE0);
    chk(fe, 1'h0);
    bus(1'h1, 4'h0, 8'h00);
    rdc(4'h4, 8'h01);
    for (int i = 0; i < 2; i++)
      begin
        pulse(i[0]);
        chk(tseen, 1'h1);
      end
    $display("Break test done");
  endtask
  task t_misc;
    chk(sc, 1'h0);
    bus(1'h1, 4'h0, 8'h10);
    rdc(4'h0, 8'h10);
    chk(sc, 1'h1);
    st <= 5'h1E;
    rdc(4'h4, 8'h3A);
    bus(1'h1, 4'h8, 8'h01);
    host <= 1'h0;
    bus(1'h1, 4'h0, 8'h80);
    rdc(4'h0, 8'h10);
    rdc(4'hC, 8'h00);
    host <= 1'h1;
    bus(1'h1, 4'h0, 8'h00);
    rdc(4'h0, 8'h00);
    $display("Status and lock test done");
  endtask
  initial
    begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
    end
  always @(posedge clk)
    begin
      cyc++;
      if (dn === 1'h1)
        ndone++;
      if (cyc == 3000)
        begin
          errors++;
          test_done;
        end
    end
  initial
    begin
      {rst_n, rd, wr, bi, hb} = 5'h00;
      host = 1'h1;
      ad = 4'h0;
      be = 4'hF;
      st = 5'h01;
      wd = 32'h0000_0000;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      t_halt_step;
      t_break;
      t_misc;
      test_done;
    end
endmodule
